// ===== hw/lcg_pkg.sv
// Constants and types shared by the logic cell input gating block
package lcg_pkg;
	localparam int CELLS     = 4;
	localparam int PICKS     = 4;
	localparam int SOURCES   = 40;
	localparam int CODE_W    = 6;
	localparam int ADDR_W    = 6;
	localparam int DATA_W    = 8;
	localparam logic [CODE_W-1:0] CODE_CELL_FIRST = 6'h1A;
	localparam logic [CODE_W-1:0] CODE_RSVD_FIRST = 6'h28;
	// Register index within a cell, cell number in the upper address bits
	localparam logic [3:0] IDX_CONTROL = 4'h0;
	localparam logic [3:0] IDX_POLARITY = 4'h1;
	localparam logic [3:0] IDX_SELECT0 = 4'h2;
	localparam logic [3:0] IDX_GATE0    = 4'h6;
	localparam int CTL_ON_BIT  = 7;
	localparam int CTL_OUT_BIT = 5;
	localparam int POL_OUT_BIT = 7;
	localparam logic [DATA_W-1:0] CONTROL_RESET = 8'h00;
	typedef enum logic [2:0] {
		FN_AND_OR, FN_OR_XOR, FN_AND4, FN_SR_LATCH,
		FN_DFF_SR, FN_DFF_R, FN_JK_R, FN_DLATCH_SR
	} lcg_func_type;
endpackage : lcg_pkg

// ===== hw/lcg_gate_if.sv
// Signals between the register side and the per-cell gating
`timescale 1ns/10ps
interface lcg_gate_if;
	logic [lcg_pkg::CODE_W-1:0] input_source_code [lcg_pkg::PICKS];
	logic [7:0]                 gate_enable_set   [lcg_pkg::PICKS];
	logic [lcg_pkg::PICKS-1:0]  gate_output_invert;
	logic [lcg_pkg::PICKS-1:0]  gate_out;
	modport cfg (output input_source_code, gate_enable_set,
		gate_output_invert, input gate_out);
	modport gating (input input_source_code, gate_enable_set,
		gate_output_invert, output gate_out);
endinterface : lcg_gate_if

// ===== hw/lcg_gating.sv
// Input multiplexers and data gates of one cell
`timescale 1ns/10ps
module lcg_gating (
	input wire logic [lcg_pkg::SOURCES-1:0] sources,
	lcg_gate_if.gating                      gif
);
	logic [lcg_pkg::PICKS-1:0] pick;

	// Reserved codes fall outside the vector and read as zero
	genvar k;
	generate
		for (k = 0; k < lcg_pkg::PICKS; k++) begin : g_pick
			always_comb begin
				if (gif.input_source_code[k] < lcg_pkg::CODE_RSVD_FIRST) begin
					pick[k] = sources[gif.input_source_code[k]];
				end else begin
					pick[k] = 1'b0;
				end
			end
		end
		for (k = 0; k < lcg_pkg::PICKS; k++) begin : g_gate
			logic [7:0] en;
			logic       conj;
			logic       clash;
			assign en = gif.gate_enable_set[k];
			always_comb begin
				conj  = 1'b1;
				clash = 1'b0;
				for (int i = 0; i < lcg_pkg::PICKS; i++) begin
					// Even bit true form, odd bit inverted form
					if (en[2*i] && !pick[i]) conj = 1'b0;
					if (en[2*i+1] && pick[i]) conj = 1'b0;
					if (en[2*i] && en[2*i+1]) clash = 1'b1;
				end
			end
			// Polarity 1 passes the AND; empty set passes its constant one
			assign gif.gate_out[k] = clash ? 1'b0
				: (gif.gate_output_invert[k] ? conj : ~conj);
		end
	endgenerate
endmodule : lcg_gating

// ===== hw/lcg_top.sv
// Register file, four gated cells and their logic function stage
//
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/10ps
module lcg_top #(
	parameter int CELLS = lcg_pkg::CELLS
) (
	input  wire logic                        CLOCK,
	input  wire logic                        RST_B,
	input  wire logic [lcg_pkg::ADDR_W-1:0]  ADDR,
	input  wire logic [lcg_pkg::DATA_W-1:0]  WR_DATA,
	input  wire logic                        WR_STB,
	input  wire logic                        RD_STB,
	output logic      [lcg_pkg::DATA_W-1:0]  RD_DATA,
	input  wire logic [lcg_pkg::SOURCES-1:0] SRC_IN,
	output logic      [CELLS-1:0]            CELL_OUT,
	output logic      [CELLS-1:0]            CELL_PIN
);
	logic       rst_meta_r;
	logic       rst_sync_r;
	logic [1:0] cell_sel;
	logic [3:0] reg_idx;

	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end

	assign cell_sel = ADDR[5:4];
	assign reg_idx  = ADDR[3:0];

	logic [lcg_pkg::DATA_W-1:0] cell_control_register [CELLS];
	logic [lcg_pkg::DATA_W-1:0] polarity_r            [CELLS];
	logic [lcg_pkg::DATA_W-1:0] source_select_register [CELLS][4];
	logic [lcg_pkg::DATA_W-1:0] gate_r                [CELLS][4];
	logic [CELLS-1:0]           out_r;
	logic [CELLS-1:0]           state_r;
	logic [CELLS-1:0]           clk_prev_r;
	logic [CELLS-1:0]           cell_on;
	logic [lcg_pkg::SOURCES-1:0] src_all;

	// Feedback comes from registered outputs so cells never form a loop
	always_comb begin
		src_all = SRC_IN;
		for (int c = 0; c < CELLS; c++) begin
			src_all[lcg_pkg::CODE_CELL_FIRST + c] = out_r[c];
		end
	end

	genvar c;
	generate
		for (c = 0; c < CELLS; c++) begin : g_cell
			lcg_gate_if   gif ();
			logic [3:0]   g;
			logic         f;
			logic         q_nxt;
			logic         rise;
			logic         wr_here;
			lcg_pkg::lcg_func_type function_choice;

			assign wr_here = WR_STB && (cell_sel == 2'(c));
			assign cell_on[c] = cell_control_register[c][lcg_pkg::CTL_ON_BIT];
			assign function_choice =
				lcg_pkg::lcg_func_type'(cell_control_register[c][2:0]);

			// Only the control register is cleared by reset
			always_ff @(posedge CLOCK or negedge rst_sync_r) begin
				if (!rst_sync_r) begin
					cell_control_register[c] <= lcg_pkg::CONTROL_RESET;
				end else if (wr_here && reg_idx == lcg_pkg::IDX_CONTROL) begin
					cell_control_register[c] <= WR_DATA;
				end
			end

			// Gating and selection keep their values across reset
			always_ff @(posedge CLOCK) begin
				if (wr_here && reg_idx == lcg_pkg::IDX_POLARITY) begin
					polarity_r[c] <= WR_DATA;
				end
				for (int i = 0; i < 4; i++) begin
					if (wr_here && reg_idx == lcg_pkg::IDX_SELECT0 + 4'(i)) begin
						source_select_register[c][i] <= WR_DATA;
					end
					if (wr_here && reg_idx == lcg_pkg::IDX_GATE0 + 4'(i)) begin
						gate_r[c][i] <= WR_DATA;
					end
				end
			end

			always_comb begin
				for (int i = 0; i < 4; i++) begin
					gif.input_source_code[i] =
						source_select_register[c][i][lcg_pkg::CODE_W-1:0];
					gif.gate_enable_set[i] = gate_r[c][i];
				end
				gif.gate_output_invert = polarity_r[c][3:0];
			end

			lcg_gating u_gating (
				.sources (src_all),
				.gif     (gif)
			);

			assign g    = gif.gate_out;
			assign rise = g[0] && !clk_prev_r[c];

			// Flip-flop functions clock on gate zero, sampled by CLOCK
			always_comb begin
				q_nxt = state_r[c];
				f     = 1'b0;
				unique case (function_choice)
					lcg_pkg::FN_AND_OR: begin
						f = (g[0] & g[1]) | (g[2] & g[3]);
					end
					lcg_pkg::FN_OR_XOR: begin
						f = (g[0] | g[1]) ^ (g[2] | g[3]);
					end
					lcg_pkg::FN_AND4: begin
						f = &g;
					end
					lcg_pkg::FN_SR_LATCH: begin
						if (g[0] | g[1]) q_nxt = 1'b1;
						else if (g[2] | g[3]) q_nxt = 1'b0;
						f = q_nxt;
					end
					lcg_pkg::FN_DFF_SR: begin
						if (g[2]) q_nxt = 1'b0;
						else if (g[3]) q_nxt = 1'b1;
						else if (rise) q_nxt = g[1];
						f = q_nxt;
					end
					lcg_pkg::FN_DFF_R: begin
						if (g[2]) q_nxt = 1'b0;
						else if (rise) q_nxt = g[1] ^ g[3];
						f = q_nxt;
					end
					lcg_pkg::FN_JK_R: begin
						if (g[2]) q_nxt = 1'b0;
						else if (rise) q_nxt = (g[1] & ~state_r[c])
							| (~g[3] & state_r[c]);
						f = q_nxt;
					end
					lcg_pkg::FN_DLATCH_SR: begin
						if (g[3]) q_nxt = 1'b0;
						else if (g[0]) q_nxt = 1'b1;
						else if (g[2]) q_nxt = g[1];
						f = q_nxt;
					end
				endcase
			end

			always_ff @(posedge CLOCK or negedge rst_sync_r) begin
				if (!rst_sync_r) begin
					state_r[c]    <= 1'b0;
					clk_prev_r[c] <= 1'b0;
					out_r[c]      <= 1'b0;
				end else begin
					state_r[c]    <= cell_on[c] ? q_nxt : 1'b0;
					clk_prev_r[c] <= g[0];
					// Output polarity last, then the enable forces zero
					out_r[c] <= cell_on[c]
						&& (f ^ polarity_r[c][lcg_pkg::POL_OUT_BIT]);
				end
			end
		end
	endgenerate

	assign CELL_OUT = out_r;
	assign CELL_PIN = out_r;

	// Read data stand one cycle after the strobe, zero otherwise
	logic [lcg_pkg::DATA_W-1:0] rd_nxt;
	always_comb begin
		rd_nxt = '0;
		for (int k = 0; k < CELLS; k++) begin
			if (cell_sel == 2'(k)) begin
				if (reg_idx == lcg_pkg::IDX_CONTROL) begin
					rd_nxt = cell_control_register[k] & 8'h87;
					rd_nxt[lcg_pkg::CTL_OUT_BIT] = out_r[k];
				end else if (reg_idx == lcg_pkg::IDX_POLARITY) begin
					rd_nxt = polarity_r[k] & 8'h8F;
				end
				for (int i = 0; i < 4; i++) begin
					if (reg_idx == lcg_pkg::IDX_SELECT0 + 4'(i)) begin
						rd_nxt = source_select_register[k][i] & 8'h3F;
					end
					if (reg_idx == lcg_pkg::IDX_GATE0 + 4'(i)) begin
						rd_nxt = gate_r[k][i];
					end
				end
			end
		end
	end

	always_ff @(posedge CLOCK or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			RD_DATA <= '0;
		end else begin
			RD_DATA <= RD_STB ? rd_nxt : 8'h00;
		end
	end
endmodule : lcg_top

// ===== bench/lcg_src_model.sv
// Stand-in for the peripheral, clock and pin signals feeding the cells
`timescale 1ns/10ps
module lcg_src_model (
	input  wire logic        clk,
	input  wire logic [3:0]  pick,
	output logic      [39:0] src
);
	// Sources above the picks toggle each cycle, source 0 every second cycle, so a wrong pick cannot hide
	logic [1:0] cnt_r = 2'b00;
	always_ff @(posedge clk)
		cnt_r <= cnt_r + 2'b01;
	assign src = {{35{cnt_r[0]}}, pick, cnt_r[1]};
endmodule : lcg_src_model

// ===== bench/lcg_top_monitor.sv
// Port checker for the logic cell input gating top
`timescale 1ns/10ps
module lcg_top_monitor #(
	parameter int CELLS = 4
) (
	input wire logic             CLOCK,
	input wire logic             RST_B,
	input wire logic [5:0]       ADDR,
	input wire logic [7:0]       WR_DATA,
	input wire logic             WR_STB,
	input wire logic             RD_STB,
	input wire logic [7:0]       RD_DATA,
	input wire logic [CELLS-1:0] CELL_OUT,
	input wire logic [CELLS-1:0] CELL_PIN
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RST_B);
	logic on0_r;
	always_ff @(posedge CLOCK or negedge RST_B)
		if (!RST_B)
			on0_r <= 1'b0;
		else if (WR_STB && ADDR == 6'h00)
			on0_r <= WR_DATA[7];
	property p_rd_idle; !RD_STB |=> RD_DATA == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
	property p_pin; CELL_PIN == CELL_OUT; endproperty
	a_pin: assert property (p_pin) else $error("pin differs");
	property p_off; !on0_r |=> CELL_OUT[0] == 1'b0; endproperty
	a_off: assert property (p_off) else $error("off cell drives");
	property p_unmapped; RD_STB && ADDR[3:0] > 4'h9 |=> RD_DATA == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read");
	property p_ctl; RD_STB && ADDR[3:0] == 4'h0 |=> (RD_DATA & 8'h58) == 0;
	endproperty
	a_ctl: assert property (p_ctl) else $error("control spare bits");
	property p_pol; RD_STB && ADDR[3:0] == 4'h1 |=> (RD_DATA & 8'h70) == 0;
	endproperty
	a_pol: assert property (p_pol) else $error("polarity spare bits");
	property p_sel;
		RD_STB && ADDR[3:0] inside {[4'h2:4'h5]} |=> RD_DATA[7:6] == 2'b00;
	endproperty
	a_sel: assert property (p_sel) else $error("select spare bits");
	property p_gate;
		WR_STB ##1 !WR_STB ##1 (RD_STB && ADDR == $past(ADDR, 2)
		&& ADDR[3:0] inside {[4'h6:4'h9]}) |=> RD_DATA == $past(WR_DATA, 3);
	endproperty
	a_gate: assert property (p_gate) else $error("gate readback");
endmodule : lcg_top_monitor
bind lcg_top lcg_top_monitor #(.CELLS(CELLS)) lcg_top_monitor_inst (
	.CLOCK(CLOCK), .RST_B(RST_B), .ADDR(ADDR), .WR_DATA(WR_DATA),
	.WR_STB(WR_STB), .RD_STB(RD_STB), .RD_DATA(RD_DATA),
	.CELL_OUT(CELL_OUT), .CELL_PIN(CELL_PIN));

// ===== bench/lcg_top_tb.sv
// Self-checking bench for the logic cell input gating top
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
	$display("ERROR %0t %h %h", $time, (a), (b)); end end
module lcg_top_tb;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [5:0]  addr = 6'h00;
	logic [7:0]  wdata = 8'h00;
	logic [7:0]  rdata;
	logic [3:0]  pick = 4'h0;
	logic [39:0] src;
	logic [3:0]  cout;
	logic [3:0]  cpin;
	int          mismatches = 0;
	int          n_checks = 0;
	logic [7:0]  sets [8] = '{8'h00, 8'h55, 8'hAA, 8'h03,
		8'h01, 8'h02, 8'h66, 8'h99};
	initial forever #50 clk = ~clk;
	lcg_src_model lcg_src_model_inst (.clk(clk), .pick(pick), .src(src));
	lcg_top lcg_top_inst (.CLOCK(clk), .RST_B(rst_b), .ADDR(addr),
		.WR_DATA(wdata), .WR_STB(wr), .RD_STB(rd), .RD_DATA(rdata),
		.SRC_IN(src), .CELL_OUT(cout), .CELL_PIN(cpin));
	task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 `CHK(rdata, e)
	endtask : rd_chk
	task automatic cell_chk(input logic [3:0] v, input logic e);
		@(posedge clk);
		pick <= v;
		@(posedge clk);
		#1 `CHK(cout[0], e)
		`CHK(cpin, cout)
	endtask : cell_chk
	// Reference gate: both forms of a pick force zero whatever the polarity
	function automatic logic gexp(logic [7:0] s, logic p, logic [3:0] v);
		logic t;
		t = 1'b1;
		for (int i = 0; i < 4; i++) begin
			if (s[2*i] && s[2*i+1])
				return 1'b0;
			if (s[2*i] && !v[i] || s[2*i+1] && v[i])
				t = 1'b0;
		end
		return p ? t : !t;
	endfunction : gexp
	task automatic t_regs;
		rd_chk(6'h20, lcg_pkg::CONTROL_RESET);
		wr_reg(6'h17, 8'hA5);
		rd_chk(6'h17, 8'hA5);
		wr_reg(6'h1C, 8'hFF);
		rd_chk(6'h1C, 8'h00);
		wr_reg(6'h00, 8'h5A);
		rd_chk(6'h00, 8'h02);
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		rd_chk(6'h00, 8'h00);
		rd_chk(6'h17, 8'hA5);
	endtask : t_regs
	task automatic t_gates;
		for (int k = 0; k < 4; k++)
			wr_reg({2'b00, lcg_pkg::IDX_SELECT0 + 4'(k)}, 8'(k + 1));
		for (int g = 0; g < 4; g++)
			for (int j = 0; j < 16; j++) begin
				for (int k = 0; k < 4; k++)
					wr_reg({2'b00, lcg_pkg::IDX_GATE0 + 4'(k)},
						k == g ? sets[j[3:1]] : 8'h00);
				wr_reg(6'h01, 8'h0F & ~(8'h01 << g) | 8'(j[0]) << g);
				// Enable once every gate is programmed; after the first pass the cell is already on
				wr_reg(6'h00, 8'h82);
				for (int v = 0; v < 16; v++)
					cell_chk(4'(v), gexp(sets[j[3:1]], j[0], 4'(v)));
			end
	endtask : t_gates
	task automatic t_off;
		wr_reg(6'h06, 8'h00);
		wr_reg(6'h09, 8'h00);
		wr_reg(6'h01, 8'h0F);
		wr_reg(6'h00, 8'h02);
		cell_chk(4'h0, 1'b0);
		wr_reg(6'h00, 8'h82);
		cell_chk(4'h0, 1'b1);
	endtask : t_off
	task automatic t_func;
		wr_reg(6'h06, 8'h01);
		wr_reg(6'h07, 8'h04);
		wr_reg(6'h08, 8'h10);
		wr_reg(6'h09, 8'h40);
		wr_reg(6'h01, 8'h0F);
		wr_reg(6'h00, 8'h80);
		for (int v = 0; v < 16; v++)
			cell_chk(4'(v), v[0] & v[1] | v[2] & v[3]);
		wr_reg(6'h00, 8'h81);
		for (int v = 0; v < 16; v++)
			cell_chk(4'(v), (v[0] | v[1]) ^ (v[2] | v[3]));
		wr_reg(6'h00, 8'h83);
		cell_chk(4'h1, 1'b1);
		cell_chk(4'h0, 1'b1);
		cell_chk(4'h4, 1'b0);
		cell_chk(4'h0, 1'b0);
	endtask : t_func
	task automatic t_mux;
		wr_reg(6'h00, 8'h82);
		wr_reg(6'h06, 8'h01);
		wr_reg(6'h02, 8'h28);
		cell_chk(4'hF, 1'b0);
		wr_reg(6'h02, 8'h3F);
		cell_chk(4'hF, 1'b0);
		// Cell fed its own inverted output must toggle every cycle
		wr_reg(6'h02, 8'h1A);
		wr_reg(6'h06, 8'h02);
		@(posedge clk);
		#1 `CHK(cout[0], 1'b1)
		@(posedge clk);
		#1 `CHK(cout[0], 1'b0)
	endtask : t_mux
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : conclude
	initial begin
		#2000000;
		mismatches++;
		conclude();
	end
	initial begin
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		t_regs();
		t_gates();
		t_off();
		t_func();
		t_mux();
		conclude();
	end
endmodule : lcg_top_tb
